// ===== src/owd_consts.vh
`ifndef OWD_CONSTS_VH
`define OWD_CONSTS_VH

// ----------------------------------------------------------------------------
// Clock and time base
// ----------------------------------------------------------------------------
`define OWD_CLK_HZ 50000000
`define OWD_US_PER_S 1000000
`define OWD_US_CYC (`OWD_CLK_HZ / `OWD_US_PER_S)

// ----------------------------------------------------------------------------
// Line timing, in microseconds
// ----------------------------------------------------------------------------
`define OWD_START_US 2
`define OWD_EOS_US 2
`define OWD_ACK_PULSE_US 512
`define OWD_ACK_VALID_US 8
`define OWD_ACK_SETTLE_US 1

// ----------------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------------
`define OWD_DEV_ADDR 8'h72
`define OWD_FRAME_BITS 16
`define OWD_REQ_BIT 7
`define OWD_SUB_HI_BIT 6
`define OWD_SUB_LO_BIT 5
`define OWD_LEVEL_MSB 4
`define OWD_LEVEL_LSB 0

// ----------------------------------------------------------------------------
// Register map, byte addresses
// ----------------------------------------------------------------------------
`define OWD_REG_CTRL 4'h0
`define OWD_REG_DATA 4'h4
`define OWD_REG_STAT 4'h8
`define OWD_REG_UNIT 4'hC

// CTRL fields.
`define OWD_CTRL_GO 0
`define OWD_CTRL_SKIP_START 1

// DATA fields: level code in 4:0, acknowledge request in 7, address in 15:8.
`define OWD_DATA_ADDR_LSB 8
`define OWD_DATA_ADDR_MSB 15

// STAT fields.
`define OWD_STAT_BUSY 0
`define OWD_STAT_DONE 1
`define OWD_STAT_ACKED 2
`define OWD_STAT_NOACK 3
`define OWD_STAT_LINE 4

// Reset values.
`define OWD_UNIT_RST 8'h05
`define OWD_LEVEL_RST 5'h1F

`endif

// ===== src/owd_host.v
// The Wishbone slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "owd_consts.vh"

module owd_host #(
    parameter ACK_PULSE_US = `OWD_ACK_PULSE_US,
    parameter ACK_VALID_US = `OWD_ACK_VALID_US
) (
    input wire clk_i,           // System clock, 50 MHz.
    input wire rst_i,           // Synchronous reset, active high.
    input wire [3:0] adr_i,     // Wishbone byte address.
    input wire [31:0] dat_i,    // Wishbone write data.
    output reg [31:0] dat_o,    // Wishbone read data.
    input wire [3:0] sel_i,     // Wishbone byte selects.
    input wire we_i,            // Wishbone write enable.
    input wire cyc_i,           // Wishbone cycle.
    input wire stb_i,           // Wishbone strobe.
    output reg ack_o,           // Wishbone acknowledge.
    input wire line_i,          // Control line level.
    output reg line_o,          // Control line drive value, always low.
    output reg line_oe_o        // Control line pull-down enable.
);

// ----------------------------------------------------------------------------
// States and time constants
// ----------------------------------------------------------------------------
localparam [2:0] ST_IDLE = 3'd0;
localparam [2:0] ST_START = 3'd1;
localparam [2:0] ST_LOW = 3'd2;
localparam [2:0] ST_HIGH = 3'd3;
localparam [2:0] ST_EOS = 3'd4;
localparam [2:0] ST_AHOLD = 3'd5;
localparam [2:0] ST_ASAMP = 3'd6;
localparam [2:0] ST_AWAIT = 3'd7;

localparam [9:0] START_US = `OWD_START_US;
localparam [9:0] EOS_US = `OWD_EOS_US;
localparam [9:0] SETTLE_US = `OWD_ACK_SETTLE_US;
localparam [9:0] VALID_US = ACK_VALID_US;
localparam [9:0] PULSE_US = ACK_PULSE_US;

// Phase length in microseconds for a bit value; long phase is three units.
function [9:0] phase_len;
    input [7:0] unit;
    input long;
    begin
        if (long) begin
            phase_len = {2'b00, unit} + {2'b00, unit} + {2'b00, unit};
        end else begin
            phase_len = {2'b00, unit};
        end
    end
endfunction

// ----------------------------------------------------------------------------
// Registers and state
// ----------------------------------------------------------------------------
reg [2:0] st_q;
reg [9:0] us_q;
reg [3:0] bit_q;
reg [15:0] shift_q;
reg skip_q;
reg skip_cfg_q;
reg [4:0] level_q;
reg req_q;
reg [7:0] addr_q;
reg [7:0] unit_q;
reg done_q;
reg acked_q;
reg noack_q;
reg go_q;
wire line_s;
wire tick;
wire bus_req;
wire bus_wr;

assign bus_req = cyc_i && stb_i;
assign bus_wr = bus_req && we_i && ack_o;

owd_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(line_i),
    .q_o(line_s)
);

// Restarting the microsecond divider on each phase change keeps every phase
// a whole number of microseconds long.
owd_tick #(
    .DIV(`OWD_US_CYC)
) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(go_q),
    .tick_o(tick)
);

// ----------------------------------------------------------------------------
// Wishbone slave
// ----------------------------------------------------------------------------
// Ack comes one cycle after the request; writes land on the edge where the
// master sees ack, so a request held on after ack is acked and written again every second cycle.
always @(posedge clk_i) begin
    if (rst_i) begin
        ack_o <= 1'b0;
        dat_o <= 32'h0000_0000;
        level_q <= `OWD_LEVEL_RST;
        req_q <= 1'b0;
        addr_q <= `OWD_DEV_ADDR;
        unit_q <= `OWD_UNIT_RST;
        skip_cfg_q <= 1'b0;
    end else begin
        ack_o <= bus_req && !ack_o;
        dat_o <= 32'h0000_0000;
        case (adr_i)
            `OWD_REG_DATA: begin
                dat_o <= {16'h0000, addr_q, req_q, 2'b00, level_q};
            end
            `OWD_REG_STAT: begin
                dat_o <= {27'h0000000, line_s, noack_q, acked_q, done_q, (st_q != ST_IDLE)};
            end
            `OWD_REG_UNIT: begin
                dat_o <= {24'h000000, unit_q};
            end
            `OWD_REG_CTRL: begin
                dat_o <= {30'h00000000, skip_cfg_q, 1'b0};
            end
            default: begin
                dat_o <= 32'h0000_0000;
            end
        endcase
        if (bus_wr && sel_i[0]) begin
            if (adr_i == `OWD_REG_DATA) begin
                level_q <= dat_i[`OWD_LEVEL_MSB:`OWD_LEVEL_LSB];
                req_q <= dat_i[`OWD_REQ_BIT];
            end
            if (adr_i == `OWD_REG_CTRL) begin
                skip_cfg_q <= dat_i[`OWD_CTRL_SKIP_START];
            end
            if (adr_i == `OWD_REG_UNIT && dat_i[7:0] != 8'h00) begin
                unit_q <= dat_i[7:0];
            end
        end
        if (bus_wr && sel_i[1] && adr_i == `OWD_REG_DATA) begin
            addr_q <= dat_i[`OWD_DATA_ADDR_MSB:`OWD_DATA_ADDR_LSB];
        end
    end
end

// ----------------------------------------------------------------------------
// Frame engine
// ----------------------------------------------------------------------------
always @(posedge clk_i) begin
    if (rst_i) begin
        st_q <= ST_IDLE;
        us_q <= 10'd0;
        bit_q <= 4'd0;
        shift_q <= 16'h0000;
        skip_q <= 1'b0;
        done_q <= 1'b0;
        acked_q <= 1'b0;
        noack_q <= 1'b0;
        go_q <= 1'b0;
        line_o <= 1'b0;
        line_oe_o <= 1'b0;
    end else begin
        go_q <= 1'b0;
        line_o <= 1'b0;
        // The divider restarts one cycle after go_q rises, so a tick in that
        // cycle would cut the new phase short by a microsecond; it is ignored.
        if (tick && !go_q) begin
            us_q <= us_q + 10'd1;
        end
        case (st_q)
            ST_IDLE: begin
                line_oe_o <= 1'b0;
                if (bus_wr && sel_i[0] && adr_i == `OWD_REG_CTRL && dat_i[`OWD_CTRL_GO]) begin
                    shift_q <= {addr_q, req_q, 2'b00, level_q};
                    bit_q <= 4'd0;
                    done_q <= 1'b0;
                    acked_q <= 1'b0;
                    noack_q <= 1'b0;
                    us_q <= 10'd0;
                    go_q <= 1'b1;
                    skip_q <= dat_i[`OWD_CTRL_SKIP_START] && line_s;
                    st_q <= ST_START;
                end
            end
            ST_START: begin
                line_oe_o <= 1'b0;
                if (skip_q || us_q >= START_US) begin
                    skip_q <= 1'b0;
                    us_q <= 10'd0;
                    go_q <= 1'b1;
                    line_oe_o <= 1'b1;
                    st_q <= ST_LOW;
                end
            end
            ST_LOW: begin
                if (us_q >= phase_len(unit_q, !shift_q[15])) begin
                    us_q <= 10'd0;
                    go_q <= 1'b1;
                    line_oe_o <= 1'b0;
                    st_q <= ST_HIGH;
                end
            end
            ST_HIGH: begin
                if (us_q >= phase_len(unit_q, shift_q[15])) begin
                    us_q <= 10'd0;
                    go_q <= 1'b1;
                    shift_q <= {shift_q[14:0], 1'b0};
                    bit_q <= bit_q + 4'd1;
                    if (bit_q[2:0] == 3'd7) begin
                        st_q <= ST_EOS;
                    end else begin
                        line_oe_o <= 1'b1;
                        st_q <= ST_LOW;
                    end
                end
            end
            ST_EOS: begin
                line_oe_o <= 1'b0;
                if (us_q >= EOS_US) begin
                    us_q <= 10'd0;
                    go_q <= 1'b1;
                    if (bit_q != 4'd0) begin
                        // The released EOS also serves as the second start.
                        st_q <= ST_LOW;
                        line_oe_o <= 1'b1;
                    end else if (req_q) begin
                        line_oe_o <= 1'b1;
                        st_q <= ST_AHOLD;
                    end else begin
                        done_q <= 1'b1;
                        st_q <= ST_IDLE;
                    end
                end
            end
            ST_AHOLD: begin
                line_oe_o <= 1'b1;
                if (us_q >= VALID_US) begin
                    us_q <= 10'd0;
                    go_q <= 1'b1;
                    line_oe_o <= 1'b0;
                    st_q <= ST_ASAMP;
                end
            end
            ST_ASAMP: begin
                line_oe_o <= 1'b0;
                // Let the pull-up and the synchroniser settle before sampling.
                if (us_q >= SETTLE_US) begin
                    us_q <= 10'd0;
                    go_q <= 1'b1;
                    if (!line_s) begin
                        acked_q <= 1'b1;
                        st_q <= ST_AWAIT;
                    end else begin
                        noack_q <= 1'b1;
                        done_q <= 1'b1;
                        st_q <= ST_IDLE;
                    end
                end
            end
            ST_AWAIT: begin
                line_oe_o <= 1'b0;
                if (line_s || us_q >= PULSE_US) begin
                    done_q <= 1'b1;
                    st_q <= ST_IDLE;
                end
            end
            default: begin
                line_oe_o <= 1'b0;
                st_q <= ST_IDLE;
            end
        endcase
    end
end

endmodule // owd_host

`default_nettype wire

// ===== src/owd_sync.v
`timescale 1ns/1ps
`default_nettype none

module owd_sync (
    input wire clk_i,  // System clock.
    input wire rst_i,  // Synchronous reset, active high.
    input wire d_i,    // Asynchronous level.
    output reg q_o     // Synchronised level.
);

reg meta_q;

// ----------------------------------------------------------------------------
// Two-stage synchroniser
// ----------------------------------------------------------------------------
// The line idles high through its pull-up, so reset to high.
always @(posedge clk_i) begin
    if (rst_i) begin
        meta_q <= 1'b1;
        q_o <= 1'b1;
    end else begin
        meta_q <= d_i;
        q_o <= meta_q;
    end
end

endmodule // owd_sync

`default_nettype wire

// ===== src/owd_tick.v
`timescale 1ns/1ps
`default_nettype none

module owd_tick #(
    parameter DIV = 50
) (
    input wire clk_i,   // System clock.
    input wire rst_i,   // Synchronous reset, active high.
    input wire clr_i,   // Restart the period.
    output reg tick_o   // One-cycle pulse every DIV cycles.
);

reg [7:0] cnt_q;

// ----------------------------------------------------------------------------
// Divider
// ----------------------------------------------------------------------------
// Clearing aligns the first tick a full period after the clear.
always @(posedge clk_i) begin
    if (rst_i || clr_i) begin
        cnt_q <= 8'h00;
        tick_o <= 1'b0;
    end else if (cnt_q == DIV[7:0] - 8'h01) begin
        cnt_q <= 8'h00;
        tick_o <= 1'b1;
    end else begin
        cnt_q <= cnt_q + 8'h01;
        tick_o <= 1'b0;
    end
end

endmodule // owd_tick

`default_nettype wire

// ===== src/placeholder_none.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== tb/owd_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module owd_dev_model #(
    parameter int VALID_CYC = 150,
    parameter int ACK_CYC = 500
) (
    input wire logic clk_i,  // Clock.
    input wire logic rst_i,  // Reset, active high.
    input wire logic line_i,  // Control line level.
    output logic pd_o,  // Acknowledge pull-down on.
    output logic [4:0] level_o,  // Stored level code.
    output logic [15:0] frame_o,  // Last complete frame.
    output logic [7:0] frames_o  // Complete frames seen.
);
    logic line_q;
    logic [15:0] sh_q;
    int lo_n;
    int hi_n;
    int bits;
    int dly;
    task automatic take_bit(input int hi);
        logic [15:0] w;
        w = {sh_q[14:0], hi >= 2 * lo_n};
        if (hi < 2 * lo_n && lo_n < 2 * hi) begin
            bits <= 0;
        end else if (bits == 15) begin
            bits <= 0;
            lo_n <= 0;
            frame_o <= w;
            frames_o <= frames_o + 8'h01;
            if (w[15:8] == 8'h72) begin
                level_o <= w[4:0];
                if (w[7]) begin
                    dly <= VALID_CYC + ACK_CYC;
                end
            end
        end else begin
            bits <= bits + 1;
            sh_q <= w;
        end
    endtask
    always @(posedge clk_i) begin
        line_q <= line_i;
        if (rst_i) begin
            level_o <= 5'h1F;
            pd_o <= 1'b0;
            frame_o <= 16'h0000;
            frames_o <= 8'h00;
            sh_q <= 16'h0000;
            lo_n <= 0;
            hi_n <= 0;
            bits <= 0;
            dly <= 0;
        end else if (dly != 0) begin
            dly <= dly - 1;
            pd_o <= (dly <= ACK_CYC) && (dly > 1);
            lo_n <= 0;
        end else if (line_q && !line_i) begin
            lo_n <= 1;
            hi_n <= 0;
            if (lo_n != 0) begin
                take_bit(hi_n);
            end
        end else if (!line_i) begin
            if (lo_n != 0) begin
                lo_n <= lo_n + 1;
            end
        end else begin
            hi_n <= hi_n + 1;
            if (lo_n != 0 && hi_n >= 2 * lo_n + 50) begin
                take_bit(hi_n);
                lo_n <= 0;
            end
        end
    end
endmodule // owd_dev_model
`default_nettype wire

// ===== tb/owd_host_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module owd_host_asserts (
    input wire logic clk_i,  // Clock.
    input wire logic rst_i,  // Reset.
    input wire logic [3:0] adr_i,  // Address.
    input wire logic [31:0] dat_i,  // Write data.
    input wire logic [31:0] dat_o,  // Read data.
    input wire logic [3:0] sel_i,  // Selects.
    input wire logic we_i,  // Write enable.
    input wire logic cyc_i,  // Cycle.
    input wire logic stb_i,  // Strobe.
    input wire logic ack_o,  // Bus acknowledge.
    input wire logic line_i,  // Line level.
    input wire logic line_o,  // Line drive value.
    input wire logic line_oe_o  // Pull-down enable.
);
    logic [7:0] lo_q;
    logic [7:0] hi_q;
    // Saturating phase counters, so a long idle span reads as 255.
    always @(posedge clk_i) begin
        if (rst_i) begin
            lo_q <= 8'hFF;
            hi_q <= 8'hFF;
        end else begin
            lo_q <= line_oe_o ? 8'h00 : ((lo_q == 8'hFF) ? lo_q : lo_q + 8'h01);
            hi_q <= !line_oe_o ? 8'h00 : ((hi_q == 8'hFF) ? hi_q : hi_q + 8'h01);
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_drive_low; line_o == 1'b0; endproperty
    a_drive_low: assert property (p_drive_low)
        else $error("line drive value not low");
    property p_release_min; $rose(line_oe_o) |-> lo_q >= 8'h64; endproperty
    a_release_min: assert property (p_release_min)
        else $error("line released for less than 2 us");
    property p_pull_min; $fell(line_oe_o) |-> hi_q >= 8'h64; endproperty
    a_pull_min: assert property (p_pull_min)
        else $error("line pulled for less than 2 us");
    property p_ack_hold; (!line_oe_o && !line_i) |=> !line_oe_o; endproperty
    a_ack_hold: assert property (p_ack_hold)
        else $error("host pulled while the device held the line");
    property p_reset; disable iff (1'b0) rst_i |=> !ack_o && !line_oe_o; endproperty
    a_reset: assert property (p_reset)
        else $error("outputs active after reset");
    property p_ack_answer; (cyc_i && stb_i && !ack_o) |=> ack_o; endproperty
    a_ack_answer: assert property (p_ack_answer)
        else $error("bus request not answered in one cycle");
    property p_ack_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("bus acknowledge without request");
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("bus acknowledge longer than one cycle");
endmodule // owd_host_asserts
`default_nettype wire

// ===== tb/owd_host_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "owd_consts.vh"
module owd_host_bench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] adr_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [3:0] sel_i = 4'h0;
    logic we_i = 1'b0;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    wire [31:0] dat_o;
    wire ack_o;
    wire line_o;
    wire line_oe_o;
    wire line_i;
    wire dev_pd;
    wire [4:0] level;
    wire [15:0] dev_frame;
    wire [7:0] frames;
    int errors = 0;
    int samples_checked = 0;
    logic [31:0] rd;
    // Pulled-up wire: low while either side pulls it.
    assign line_i = !((line_oe_o && !line_o) || dev_pd);
    owd_host #(.ACK_PULSE_US(20), .ACK_VALID_US(4)) i_owd_host (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
        .dat_i(dat_i), .dat_o(dat_o), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
        .line_i(line_i), .line_o(line_o), .line_oe_o(line_oe_o));
    owd_dev_model #(.VALID_CYC(150), .ACK_CYC(500)) i_owd_dev_model (.clk_i(clk_i), .rst_i(rst_i),
        .line_i(line_i), .pd_o(dev_pd), .level_o(level), .frame_o(dev_frame), .frames_o(frames));
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            errors++;
        end
    endtask
    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        adr_i <= a;
        we_i <= w;
        dat_i <= d;
        sel_i <= 4'hF;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (ack_o !== 1'b1) begin
            errors++;
            end_of_test();
        end
    endtask
    // One frame from order to status; the model's view is compared too.
    task automatic run_frame(input logic [7:0] a, input logic [7:0] d, input logic skip, input logic [3:0] st,
        input logic [4:0] lv);
        int n;
        logic [7:0] f0;
        f0 = frames;
        wb(`OWD_REG_DATA, 1'b1, {16'h0, a, d}, rd);
        wb(`OWD_REG_DATA, 1'b0, 32'h0, rd);
        chk(rd, {16'h0, a, d & 8'h9F});
        wb(`OWD_REG_CTRL, 1'b1, {30'h0, skip, 1'b1}, rd);
        wb(`OWD_REG_STAT, 1'b0, 32'h0, rd);
        chk({31'h0, rd[0]}, 32'h1);
        n = 0;
        do begin
            wb(`OWD_REG_STAT, 1'b0, 32'h0, rd);
            n++;
        end while (rd[1] !== 1'b1 && n < 15000);
        if (rd[1] !== 1'b1) begin
            errors++;
            end_of_test();
        end
        chk({28'h0, rd[3:0]}, {28'h0, st});
        chk({16'h0, dev_frame}, {16'h0, a, d & 8'h9F});
        chk({24'h0, frames}, {24'h0, f0 + 8'h01});
        chk({27'h0, level}, {27'h0, lv});
    endtask
    task automatic s_reset_values();
        wb(`OWD_REG_DATA, 1'b0, 32'h0, rd);
        chk(rd, 32'h0000721F);
        chk({27'h0, level}, 32'h1F);
        wb(`OWD_REG_STAT, 1'b0, 32'h0, rd);
        chk(rd, 32'h00000010);
        wb(4'h2, 1'b1, 32'hFFFFFFFF, rd);
        wb(4'h2, 1'b0, 32'h0, rd);
        chk(rd, 32'h0);
        wb(`OWD_REG_UNIT, 1'b1, 32'h0, rd);
        wb(`OWD_REG_UNIT, 1'b0, 32'h0, rd);
        chk(rd, 32'h5);
        wb(`OWD_REG_UNIT, 1'b1, 32'h7, rd);
        wb(`OWD_REG_UNIT, 1'b0, 32'h0, rd);
        chk(rd, 32'h7);
    endtask
    task automatic s_plain();
        run_frame(8'h72, 8'h6B, 1'b1, 4'b0010, 5'h0B);
    endtask
    task automatic s_ack();
        run_frame(8'h72, 8'h84, 1'b0, 4'b0110, 5'h04);
    endtask
    task automatic s_foreign();
        run_frame(8'h55, 8'h91, 1'b0, 4'b1010, 5'h04);
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (200) @(posedge clk_i);
        s_reset_values();
        s_plain();
        s_ack();
        s_foreign();
        end_of_test();
    end
endmodule // owd_host_bench
bind owd_host owd_host_asserts i_owd_host_asserts (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
    .dat_o(dat_o), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .line_i(line_i),
    .line_o(line_o), .line_oe_o(line_oe_o));
`default_nettype wire
